// ==== rtl/bfr_pkg.sv ====
// Purpose: constants for the bus fault reaction and fault code block
// Assumes: object access arrives as a decoded index/data strobe pair
// Notes: object indices are kept as printed
package bfr_pkg;
    // object indices
    localparam logic [15:0] IDX_REACTION = 16'h6007;
    localparam logic [15:0] IDX_FAULT_CODE = 16'h603F;
    localparam logic [15:0] IDX_REACTION_PARAM = 16'h0184;
    localparam logic [15:0] IDX_CURRENT_FAULT = 16'h0104;
    // reaction settings, object coding
    localparam logic [15:0] REACT_NONE = 16'h0000;
    localparam logic [15:0] REACT_FAULT = 16'h0001;
    localparam logic [15:0] REACT_SWITCH_OFF = 16'h0002;
    localparam logic [15:0] REACT_QSTOP = 16'h0003;
    localparam logic [15:0] REACT_RAMP_ERR = 16'hFFFF;
    localparam logic [15:0] REACT_QSTOP_ERR = 16'hFFFE;
    localparam logic [15:0] REACT_RESET = 16'h0001;
    // internal parameter coding of the negative settings
    localparam logic [15:0] PARAM_RAMP_ERR = 16'h0004;
    localparam logic [15:0] PARAM_QSTOP_ERR = 16'h0005;
    // command source selection value for state machine control
    localparam logic [15:0] SRC_STATE_MACHINE = 16'h0001;
    // fault classes
    localparam logic [3:0] CLS_NONE = 4'h0;
    localparam logic [3:0] CLS_OVERLOAD = 4'h1;
    localparam logic [3:0] CLS_CASE_TEMP = 4'h2;
    localparam logic [3:0] CLS_INSIDE_TEMP = 4'h3;
    localparam logic [3:0] CLS_MOTOR_TEMP = 4'h4;
    localparam logic [3:0] CLS_PHASE_CURR = 4'h5;
    localparam logic [3:0] CLS_DC_LINK = 4'h7;
    localparam logic [3:0] CLS_ELEC_SUPPLY = 4'h8;
    localparam logic [3:0] CLS_EARTH_FAULT = 4'hD;
    // profile codes
    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_OVERLOAD = 16'h2310;
    localparam logic [15:0] CODE_CASE_TEMP = 16'h4210;
    localparam logic [15:0] CODE_INSIDE_TEMP = 16'h4110;
    localparam logic [15:0] CODE_MOTOR_TEMP = 16'h4310;
    localparam logic [15:0] CODE_PHASE_CURR = 16'h2340;
    localparam logic [15:0] CODE_DC_LINK = 16'h3210;
    localparam logic [15:0] CODE_ELEC_SUPPLY = 16'h5111;
    localparam logic [15:0] CODE_EARTH_FAULT = 16'h2330;
    localparam logic [15:0] CODE_GENERIC = 16'h1000;
    // drive commands issued to the drive state machine
    typedef enum logic [2:0] {
        BFR_CMD_NONE, BFR_CMD_FAULT, BFR_CMD_DISABLE_VOLTAGE,
        BFR_CMD_QUICK_STOP, BFR_CMD_DISABLE_OP
    } bfr_cmd_e;
endpackage

// ==== rtl/bfr_code_map.sv ====
// Purpose: maps an internal fault class to its profile error code
// Assumes: class is stable while a fault is reported
// Notes: purely combinational
`timescale 1ns/1ps
module bfr_code_map (
    // fault class
    input wire logic [3:0] class_in,
    // profile code
    output logic [15:0] code_out,
    output logic generic_out
);
    always_comb begin
        generic_out = 1'b0;
        case (class_in)
            bfr_pkg::CLS_NONE: code_out = bfr_pkg::CODE_NONE;
            bfr_pkg::CLS_OVERLOAD: code_out = bfr_pkg::CODE_OVERLOAD;
            bfr_pkg::CLS_CASE_TEMP: code_out = bfr_pkg::CODE_CASE_TEMP;
            bfr_pkg::CLS_INSIDE_TEMP: code_out = bfr_pkg::CODE_INSIDE_TEMP;
            bfr_pkg::CLS_MOTOR_TEMP: code_out = bfr_pkg::CODE_MOTOR_TEMP;
            bfr_pkg::CLS_PHASE_CURR: code_out = bfr_pkg::CODE_PHASE_CURR;
            bfr_pkg::CLS_DC_LINK: code_out = bfr_pkg::CODE_DC_LINK;
            bfr_pkg::CLS_ELEC_SUPPLY: code_out = bfr_pkg::CODE_ELEC_SUPPLY;
            bfr_pkg::CLS_EARTH_FAULT: code_out = bfr_pkg::CODE_EARTH_FAULT;
            default: begin
                code_out = bfr_pkg::CODE_GENERIC;
                generic_out = 1'b1;
            end
        endcase
    end
endmodule

// ==== rtl/bfr_top.sv ====
// Purpose: bus connection failure reaction and last fault code objects
// Assumes: object reads/writes arrive decoded from the SDO server
// Notes: drive state machine lives outside; this block issues commands
//
// Operation
// - BusOff, guarding, heartbeat, SYNC, RxPDO length or leaving operational flag failure.
// - setting 0 takes no action and keeps the operating point.
// - setting 1, the default, sends the drive straight to fault.
// - setting 2 issues disable voltage and goes to switch-on-disabled.
// - setting 3 under state-machine control quick-stops to switch-on-disabled.
// - setting 3 under contact control goes to fault immediately.
// - setting -1 ramps down, then faults once at standstill.
// - setting -2 quick-stops, then faults once at standstill.
// - settings -2 to 3 accepted; only the setting 3 response depends on command source.
// - object and internal parameter are one value; 4,5 mean -1,-2.
// - save command stores a written setting, restored at power-up.
// - fault reset refused until the node is operational again.
// - fault reset refused until the failure cause is removed.
// - after a length error, RxPDO data dropped up to and including the first correct frame.
// - last fault profile code held in read-only 16-bit object.
// - code 0000 with no fault, 2310 for inverter overload.
// - 4210 case, 4110 inside, 4310 motor temperature faults.
// - 2340 phase current, 3210 DC link, 5111 electronics supply.
// - 2330 earth fault; any other class reports 1000.
// - native fault code readable via current-fault parameter.
// - emergency carries profile code in bytes 0-1, native in 4-7.
// - command source value 1 means state-machine control.
`timescale 1ns/1ps
module bfr_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // object access
    input wire logic obj_wr_in,
    input wire logic obj_rd_in,
    input wire logic [15:0] obj_index_in,
    input wire logic [15:0] obj_wdata_in,
    output logic [15:0] obj_rdata_out,
    output logic obj_ack_out,
    output logic obj_err_out,
    // non-volatile store
    input wire logic save_cmd_in,
    input wire logic nv_valid_in,
    input wire logic [15:0] nv_value_in,
    output logic nv_wr_out,
    output logic [15:0] nv_wdata_out,
    // failure sources
    input wire logic bus_off_in,
    input wire logic guard_lost_in,
    input wire logic heartbeat_lost_in,
    input wire logic sync_err_in,
    input wire logic rxpdo_len_err_in,
    input wire logic nmt_operational_in,
    input wire logic rxpdo_frame_in,
    input wire logic rxpdo_len_ok_in,
    output logic rxpdo_accept_out,
    // drive state machine
    input wire logic [15:0] cmd_source_in,
    input wire logic standstill_in,
    input wire logic fault_reset_in,
    output logic [2:0] drive_cmd_out,
    output logic drive_cmd_valid_out,
    output logic reset_accepted_out,
    // internal faults
    input wire logic fault_event_in,
    input wire logic [3:0] fault_class_in,
    input wire logic [15:0] native_code_in,
    output logic [15:0] current_fault_out,
    output logic emcy_valid_out,
    output logic [63:0] emcy_data_out
);
    typedef enum logic [1:0] {BFR_IDLE, BFR_WAIT_STOP, BFR_DONE} bfr_state_e;

    // object value to internal coding
    function automatic logic [15:0] bfr_to_param(input logic [15:0] v);
        if (v == bfr_pkg::REACT_RAMP_ERR) begin
            return bfr_pkg::PARAM_RAMP_ERR;
        end else if (v == bfr_pkg::REACT_QSTOP_ERR) begin
            return bfr_pkg::PARAM_QSTOP_ERR;
        end else begin
            return v;
        end
    endfunction

    function automatic logic bfr_legal(input logic [15:0] v);
        return ($signed(v) >= -16'sd2) && ($signed(v) <= 16'sd3);
    endfunction

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    logic [15:0] reaction;
    logic [15:0] next_reaction;
    logic dirty;
    logic next_dirty;
    logic nv_loaded;
    logic next_nv_loaded;
    bfr_state_e state;
    bfr_state_e next_state;
    logic op_prev;
    logic next_op_prev;
    logic failed;
    logic next_failed;
    logic len_block;
    logic next_len_block;
    logic [15:0] last_code;
    logic [15:0] next_last_code;
    logic [15:0] current_fault;
    logic [15:0] next_current_fault;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic ack;
    logic next_ack;
    logic err;
    logic next_err;
    logic [2:0] cmd;
    logic [2:0] next_cmd;
    logic cmd_valid;
    logic next_cmd_valid;
    logic nv_wr;
    logic next_nv_wr;
    logic emcy_valid;
    logic next_emcy_valid;
    logic [63:0] emcy_data;
    logic [63:0] next_emcy_data;
    logic rst_ok;
    logic next_rst_ok;

    logic [15:0] mapped_code;
    logic fail_event;
    logic sm_ctrl;
    logic cause_present;

    bfr_code_map u_map (
        .class_in(fault_class_in),
        .code_out(mapped_code),
        .generic_out()
    );

    //------------------------------------------------------------
    // failure detection
    //------------------------------------------------------------
    assign fail_event = bus_off_in | guard_lost_in | heartbeat_lost_in | sync_err_in
                        | rxpdo_len_err_in | (op_prev & ~nmt_operational_in);
    assign sm_ctrl = (cmd_source_in == bfr_pkg::SRC_STATE_MACHINE);
    assign cause_present = bus_off_in | guard_lost_in | heartbeat_lost_in | sync_err_in
                           | len_block;

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb begin
        next_reaction = reaction;
        next_dirty = dirty;
        next_nv_loaded = nv_loaded;
        next_state = state;
        next_op_prev = nmt_operational_in;
        next_failed = failed;
        next_len_block = len_block;
        next_last_code = last_code;
        next_current_fault = current_fault;
        next_rdata = rdata;
        next_ack = 1'b0;
        next_err = 1'b0;
        next_cmd = cmd;
        next_cmd_valid = 1'b0;
        next_nv_wr = 1'b0;
        next_emcy_valid = 1'b0;
        next_emcy_data = emcy_data;
        next_rst_ok = 1'b0;
        // stored value overrides the parameter once after power-up
        if (!nv_loaded && nv_valid_in) begin
            next_nv_loaded = 1'b1;
            if (bfr_legal(nv_value_in)) begin
                next_reaction = bfr_to_param(nv_value_in);
            end
        end
        // object access
        if (obj_wr_in) begin
            next_ack = 1'b1;
            if (obj_index_in == bfr_pkg::IDX_REACTION && bfr_legal(obj_wdata_in)) begin
                next_reaction = bfr_to_param(obj_wdata_in);
                next_dirty = 1'b1;
            end else if (obj_index_in == bfr_pkg::IDX_REACTION_PARAM &&
                         obj_wdata_in <= bfr_pkg::PARAM_QSTOP_ERR) begin
                next_reaction = obj_wdata_in;
            end else begin
                next_err = 1'b1;
            end
        end else if (obj_rd_in) begin
            next_ack = 1'b1;
            if (obj_index_in == bfr_pkg::IDX_REACTION) begin
                if (reaction == bfr_pkg::PARAM_RAMP_ERR) begin
                    next_rdata = bfr_pkg::REACT_RAMP_ERR;
                end else if (reaction == bfr_pkg::PARAM_QSTOP_ERR) begin
                    next_rdata = bfr_pkg::REACT_QSTOP_ERR;
                end else begin
                    next_rdata = reaction;
                end
            end else if (obj_index_in == bfr_pkg::IDX_REACTION_PARAM) begin
                next_rdata = reaction;
            end else if (obj_index_in == bfr_pkg::IDX_FAULT_CODE) begin
                next_rdata = last_code;
            end else if (obj_index_in == bfr_pkg::IDX_CURRENT_FAULT) begin
                next_rdata = current_fault;
            end else begin
                next_rdata = 16'h0000;
                next_err = 1'b1;
            end
        end
        // save command
        if (save_cmd_in && dirty) begin
            next_nv_wr = 1'b1;
            next_dirty = 1'b0;
        end
        // length error gating
        if (rxpdo_len_err_in) begin
            next_len_block = 1'b1;
        end else if (rxpdo_frame_in && rxpdo_len_ok_in) begin
            next_len_block = 1'b0;
        end
        // internal fault capture
        if (fault_event_in) begin
            next_last_code = mapped_code;
            next_current_fault = native_code_in;
            next_emcy_valid = 1'b1;
            next_emcy_data = {16'h0000, native_code_in, 16'h0000, mapped_code};
        end
        // reaction sequencer
        case (state)
            BFR_IDLE: begin
                if (fail_event) begin
                    next_failed = 1'b1;
                    next_cmd_valid = 1'b1;
                    next_state = BFR_DONE;
                    case (reaction)
                        bfr_pkg::REACT_NONE: begin
                            next_cmd = bfr_pkg::BFR_CMD_NONE;
                            next_cmd_valid = 1'b0;
                        end
                        bfr_pkg::REACT_FAULT: next_cmd = bfr_pkg::BFR_CMD_FAULT;
                        bfr_pkg::REACT_SWITCH_OFF: next_cmd = bfr_pkg::BFR_CMD_DISABLE_VOLTAGE;
                        bfr_pkg::REACT_QSTOP: begin
                            next_cmd = sm_ctrl ? bfr_pkg::BFR_CMD_QUICK_STOP : bfr_pkg::BFR_CMD_FAULT;
                        end
                        bfr_pkg::PARAM_RAMP_ERR: begin
                            next_cmd = bfr_pkg::BFR_CMD_DISABLE_OP;
                            next_state = BFR_WAIT_STOP;
                        end
                        bfr_pkg::PARAM_QSTOP_ERR: begin
                            next_cmd = bfr_pkg::BFR_CMD_QUICK_STOP;
                            next_state = BFR_WAIT_STOP;
                        end
                        default: next_cmd = bfr_pkg::BFR_CMD_FAULT;
                    endcase
                end
            end
            BFR_WAIT_STOP: begin
                if (standstill_in) begin
                    next_cmd = bfr_pkg::BFR_CMD_FAULT;
                    next_cmd_valid = 1'b1;
                    next_state = BFR_DONE;
                end
            end
            default: begin
                if (fault_reset_in && failed && nmt_operational_in && !cause_present) begin
                    next_rst_ok = 1'b1;
                    next_failed = 1'b0;
                    next_cmd = bfr_pkg::BFR_CMD_NONE;
                    next_state = BFR_IDLE;
                end
            end
        endcase
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reaction <= bfr_pkg::REACT_RESET;
            dirty <= 1'b0;
            nv_loaded <= 1'b0;
            state <= BFR_IDLE;
            op_prev <= 1'b0;
            failed <= 1'b0;
            len_block <= 1'b0;
            last_code <= bfr_pkg::CODE_NONE;
            current_fault <= 16'h0000;
            rdata <= 16'h0000;
            ack <= 1'b0;
            err <= 1'b0;
            cmd <= bfr_pkg::BFR_CMD_NONE;
            cmd_valid <= 1'b0;
            nv_wr <= 1'b0;
            emcy_valid <= 1'b0;
            emcy_data <= 64'h0;
            rst_ok <= 1'b0;
        end else begin
            reaction <= next_reaction;
            dirty <= next_dirty;
            nv_loaded <= next_nv_loaded;
            state <= next_state;
            op_prev <= next_op_prev;
            failed <= next_failed;
            len_block <= next_len_block;
            last_code <= next_last_code;
            current_fault <= next_current_fault;
            rdata <= next_rdata;
            ack <= next_ack;
            err <= next_err;
            cmd <= next_cmd;
            cmd_valid <= next_cmd_valid;
            nv_wr <= next_nv_wr;
            emcy_valid <= next_emcy_valid;
            emcy_data <= next_emcy_data;
            rst_ok <= next_rst_ok;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign obj_rdata_out = rdata;
    assign obj_ack_out = ack;
    assign obj_err_out = err;
    assign nv_wr_out = nv_wr;
    assign nv_wdata_out = (reaction == bfr_pkg::PARAM_RAMP_ERR) ? bfr_pkg::REACT_RAMP_ERR :
                          (reaction == bfr_pkg::PARAM_QSTOP_ERR) ? bfr_pkg::REACT_QSTOP_ERR : reaction;
    assign rxpdo_accept_out = rxpdo_frame_in & ~len_block & ~rxpdo_len_err_in;
    assign drive_cmd_out = cmd;
    assign drive_cmd_valid_out = cmd_valid;
    assign reset_accepted_out = rst_ok;
    assign current_fault_out = current_fault;
    assign emcy_valid_out = emcy_valid;
    assign emcy_data_out = emcy_data;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    fault_direct_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == BFR_IDLE && fail_event && reaction == bfr_pkg::REACT_FAULT)
        |=> (cmd_valid && cmd == bfr_pkg::BFR_CMD_FAULT))
        else $error("setting 1 did not fault");
    no_reaction_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == BFR_IDLE && fail_event && reaction == bfr_pkg::REACT_NONE) |=> !cmd_valid)
        else $error("setting 0 issued a command");
    qstop_src_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == BFR_IDLE && fail_event && reaction == bfr_pkg::REACT_QSTOP && sm_ctrl)
        |=> (cmd == bfr_pkg::BFR_CMD_QUICK_STOP))
        else $error("setting 3 did not quick stop");
    wait_stop_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == BFR_WAIT_STOP && !standstill_in) |=> !(cmd_valid && cmd == bfr_pkg::BFR_CMD_FAULT))
        else $error("fault before standstill");
    reset_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rst_ok |-> $past(nmt_operational_in) && !$past(cause_present))
        else $error("fault reset accepted too early");
    once_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == BFR_DONE) ##1 (state == BFR_DONE) |-> !cmd_valid)
        else $error("reaction repeated");
    len_drop_a: assert property (@(posedge clk_in) disable iff (rst_in)
        len_block |-> !rxpdo_accept_out)
        else $error("rxpdo accepted while blocked");
    emcy_layout_a: assert property (@(posedge clk_in) disable iff (rst_in)
        fault_event_in |=> emcy_valid && emcy_data[15:0] == $past(mapped_code))
        else $error("emergency code bytes wrong");
endmodule

// ==== dv/bfr_master_model.sv ====
// Purpose: master-side model driving link state and fault reset requests
// Assumes: the device samples on rising clk_in
// Notes: guard loss stands for the master stopping node guarding
`timescale 1ns/1ps
module bfr_master_model (
    // clock
    input wire logic clk_in,
    // link state and reset request
    output logic nmt_operational_out,
    output logic guard_lost_out,
    output logic fault_reset_out
);
    initial begin
        nmt_operational_out = 1'b1;
        guard_lost_out = 1'b0;
        fault_reset_out = 1'b0;
    end
    // reset request lasts one cycle
    always @(posedge clk_in) begin
        fault_reset_out <= 1'b0;
    end
    task automatic drop_link(input bit guard);
        @(negedge clk_in);
        if (guard) guard_lost_out = 1'b1;
        else nmt_operational_out = 1'b0;
    endtask
    // operational again and guarding restarted, before the second reset request
    task automatic recover();
        @(negedge clk_in);
        nmt_operational_out = 1'b1;
        guard_lost_out = 1'b0;
    endtask
    task automatic req_reset();
        @(negedge clk_in);
        fault_reset_out = 1'b1;
    endtask
endmodule

// ==== dv/tb_top.sv ====
// Purpose: object access, failure reaction and fault code tests
// Assumes: inputs change at the falling edge
// Notes: pulse inputs fall back at the next rising edge
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic clk_in, rst_in, obj_wr_in, obj_rd_in, obj_ack_out, obj_err_out, save_cmd_in, nv_valid_in, nv_wr_out;
    logic bus_off_in, guard_lost_in, heartbeat_lost_in, sync_err_in, rxpdo_len_err_in, nmt_operational_in;
    logic rxpdo_frame_in, rxpdo_len_ok_in, rxpdo_accept_out, standstill_in, fault_reset_in, drive_cmd_valid_out;
    logic reset_accepted_out, fault_event_in, emcy_valid_out;
    logic [15:0] obj_index_in, obj_wdata_in, obj_rdata_out, nv_value_in, nv_wdata_out, cmd_source_in;
    logic [15:0] native_code_in, current_fault_out;
    logic [2:0] drive_cmd_out;
    logic [3:0] fault_class_in;
    logic [63:0] emcy_data_out;
    logic [4:0] evt;
    int err_count = 0;
    int n_compared = 0;
    bit got;
    logic er_v;
    logic [15:0] rs [7] = '{16'h0001, 16'h0002, 16'h0003, 16'h0003, 16'hFFFF, 16'hFFFE, 16'h0000};
    logic [2:0] c1 [7] = '{3'd1, 3'd2, 3'd3, 3'd1, 3'd4, 3'd3, 3'd0};
    logic [3:0] fc [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'hD, 4'h6};
    logic [15:0] pc [10] = '{16'h0000, 16'h2310, 16'h4210, 16'h4110, 16'h4310, 16'h2340, 16'h3210,
        16'h5111, 16'h2330, 16'h1000};
    assign evt = {nv_wr_out, reset_accepted_out, emcy_valid_out, drive_cmd_valid_out, obj_ack_out | obj_err_out};
    bfr_top dut (.clk_in, .rst_in, .obj_wr_in, .obj_rd_in, .obj_index_in, .obj_wdata_in, .obj_rdata_out,
        .obj_ack_out, .obj_err_out, .save_cmd_in, .nv_valid_in, .nv_value_in, .nv_wr_out, .nv_wdata_out,
        .bus_off_in, .guard_lost_in, .heartbeat_lost_in, .sync_err_in, .rxpdo_len_err_in, .nmt_operational_in,
        .rxpdo_frame_in, .rxpdo_len_ok_in, .rxpdo_accept_out, .cmd_source_in, .standstill_in, .fault_reset_in,
        .drive_cmd_out, .drive_cmd_valid_out, .reset_accepted_out, .fault_event_in, .fault_class_in,
        .native_code_in, .current_fault_out, .emcy_valid_out, .emcy_data_out);
    bfr_master_model master (.clk_in, .nmt_operational_out(nmt_operational_in),
        .guard_lost_out(guard_lost_in), .fault_reset_out(fault_reset_in));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        {obj_wr_in, obj_rd_in, save_cmd_in, rxpdo_len_err_in, rxpdo_frame_in, fault_event_in} <= '0;
    end
    // ------------------------------------------------------------
    // access and wait tasks
    // ------------------------------------------------------------
    task print_verdict();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task wait_evt(input logic [4:0] m, input int lim);
        got = 0;
        for (int i = 0; i < lim && !got; i++) begin
            @(negedge clk_in);
            got = |(evt & m);
        end
    endtask
    task need(input logic [4:0] m);
        wait_evt(m, 6);
        if (!got) begin
            err_count++;
            $display("CHECK FAILED t=%0t timeout", $time);
            print_verdict();
        end
    endtask
    task acc(input bit w, input logic [15:0] idx, input logic [15:0] d);
        @(negedge clk_in);
        obj_wr_in = w;
        obj_rd_in = !w;
        obj_index_in = idx;
        obj_wdata_in = d;
        need(5'b00001);
        er_v = obj_err_out;
    endtask
    task do_reset();
        rst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
    endtask
    task frame(input logic ok, input logic exp);
        @(negedge clk_in);
        rxpdo_frame_in = 1'b1;
        rxpdo_len_ok_in = ok;
        #1;
        `CHK(rxpdo_accept_out, exp)
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {obj_wr_in, obj_rd_in, save_cmd_in, nv_valid_in, bus_off_in, heartbeat_lost_in, sync_err_in} = '0;
        {rxpdo_len_err_in, rxpdo_frame_in, rxpdo_len_ok_in, standstill_in, fault_event_in} = '0;
        {obj_index_in, obj_wdata_in, nv_value_in, native_code_in, fault_class_in} = '0;
        cmd_source_in = 16'h0001;
        do_reset();
        acc(0, 16'h6007, 16'h0000);
        `CHK(obj_rdata_out, 16'h0001)
        acc(0, 16'h603F, 16'h0000);
        `CHK(obj_rdata_out, 16'h0000)
        acc(1, 16'h6007, 16'hFFFE);
        acc(0, 16'h0184, 16'h0000);
        `CHK(obj_rdata_out, 16'h0005)
        acc(1, 16'h0184, 16'h0004);
        acc(1, 16'h6007, 16'h0004);
        `CHK(er_v, 1'b1)
        acc(0, 16'h6007, 16'h0000);
        `CHK(obj_rdata_out, 16'hFFFF)
        acc(1, 16'h603F, 16'h1234);
        `CHK(er_v, 1'b1)
        acc(1, 16'h0555, 16'h0000);
        `CHK(er_v, 1'b1)
        @(negedge clk_in);
        save_cmd_in = 1'b1;
        need(5'b10000);
        `CHK(nv_wdata_out, 16'hFFFF)
        nv_valid_in = 1'b1;
        nv_value_in = 16'hFFFE;
        do_reset();
        acc(0, 16'h6007, 16'h0000);
        `CHK(obj_rdata_out, 16'hFFFE)
        nv_valid_in = 1'b0;
        // settings chosen cover the forcing values too
        for (int k = 0; k < 7; k++) begin
            acc(1, 16'h6007, rs[k]);
            cmd_source_in = (k == 3) ? 16'h0000 : 16'h0001;
            @(negedge clk_in);
            case (k)
                0, 6: bus_off_in = 1'b1;
                2: heartbeat_lost_in = 1'b1;
                3: sync_err_in = 1'b1;
                4: rxpdo_len_err_in = 1'b1;
                default: master.drop_link(k == 1);
            endcase
            wait_evt(5'b00010, 5);
            `CHK(got, (c1[k] != 3'd0))
            if (got) `CHK(drive_cmd_out, c1[k])
            if (k == 4 || k == 5) begin
                wait_evt(5'b00010, 4);
                `CHK(got, 1'b0)
                standstill_in = 1'b1;
                need(5'b00010);
                `CHK(drive_cmd_out, 3'd1)
                standstill_in = 1'b0;
            end
            master.req_reset();
            rxpdo_len_err_in = 1'b1;
            wait_evt(5'b01010, 5);
            `CHK(got, 1'b0)
            {bus_off_in, heartbeat_lost_in, sync_err_in} = '0;
            master.recover();
            frame(1'b0, 1'b0);
            frame(1'b1, 1'b0);
            frame(1'b1, 1'b1);
            master.req_reset();
            wait_evt(5'b01000, 5);
            `CHK(got, 1'b1)
        end
        for (int k = 0; k < 10; k++) begin
            @(negedge clk_in);
            fault_event_in = 1'b1;
            fault_class_in = fc[k];
            native_code_in = 16'h0A00 + 16'(k);
            need(5'b00100);
            `CHK(emcy_data_out[15:0], pc[k])
            `CHK(emcy_data_out[63:32], {16'h0000, native_code_in})
            `CHK(current_fault_out, native_code_in)
            acc(0, 16'h603F, 16'h0000);
            `CHK(obj_rdata_out, pc[k])
            acc(0, 16'h0104, 16'h0000);
            `CHK(obj_rdata_out, native_code_in)
        end
        print_verdict();
    end
endmodule
